//--- amprc_pkg.sv
// Package for the master page control register block.
// Assumes an 8-bit register port with byte offsets as printed.
package amprc_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_INPUT_COUPLING   = 8'h4F;
    localparam logic [7:0] ADDR_SYSREF_CONTROL   = 8'h53;
    localparam logic [7:0] ADDR_SYSREF_MANUAL    = 8'h54;
    localparam logic [7:0] ADDR_POWERDOWN_CTRL   = 8'h55;
    localparam logic [7:0] ADDR_PERF_HIGH        = 8'h56;
    localparam logic [7:0] ADDR_OVERRANGE_OUT    = 8'h59;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_INPUT_DC_BIAS     = 0;
    localparam int BIT_SYSREF_IGNORE     = 6;
    localparam int BIT_SYSREF_HIGH_CM    = 1;
    localparam int BIT_SYSREF_SOFT_LEVEL = 0;
    localparam int BIT_SYSREF_SOFT_DRIVE = 7;
    localparam int BIT_POWERDOWN_BY_REG  = 4;
    localparam int BIT_PERF_SETTING3     = 2;
    localparam int BIT_CHB_FAST_OVERRANGE_FLAG_OUT      = 7;
    localparam int BIT_ALWAYS_ONE        = 5;

    // ------------------------------------------------------------------
    // Reset values and bias selection
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam logic       BIAS_LOW_600    = 1'b0;
    localparam logic       BIAS_HIGH_5K    = 1'b1;

endpackage : amprc_pkg

//--- amprc_ctrl_bit.sv
// Single control bit with write capture and asynchronous reset.
// Assumes the register port strobes are synchronous to CLK_I.
`timescale 1ns/10ps
module amprc_ctrl_bit #(
    parameter logic RESET_VALUE = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic resetn_i,
    input  wire logic wr_en_i,
    input  wire logic wr_bit_i,
    output logic      bit_o
);
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            bit_o <= RESET_VALUE;
        else if (wr_en_i)
            bit_o <= wr_bit_i;
    end
endmodule : amprc_ctrl_bit

//--- amprc_regs.sv
// Master page control registers: input bias, SYSREF control, register
// power-down, performance setting top bit and overrange output routing.
// Assumes a host master with one-cycle strobes and reads answered next cycle.
//
// Summary of operation
// - Dc-coupling bit selects high bias resistance
// - Ignore bit blocks the SYSREF input
// - Enables higher SYSREF common-mode input support
// - Manual SYSREF enable, resets disabled
// - Register power-down uses selected mask
// - Write-only bit routes channel B overrange out
// - Table select picks mask one or two
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module amprc_regs
    import amprc_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RESETN_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic       SYSREF_I,
    input  wire logic       POWERDOWN_TABLE_SELECT_I,
    input  wire logic [7:0] POWERDOWN_MASK1_I,
    input  wire logic [7:0] POWERDOWN_MASK2_I,
    input  wire logic       FAST_OVERRANGE_FLAG_B_I,
    input  wire logic       SERIAL_DATA_I,
    output logic [7:0]      RDATA_O,
    output logic            INPUT_DC_BIAS_SELECT_O,
    output logic            SYSREF_HIGH_CM_ENABLE_O,
    output logic            SYSREF_O,
    output logic [7:0]      POWERDOWN_BLOCKS_O,
    output logic            PERFORMANCE_SETTING3_O,
    output logic            SERIAL_DATA_OUT_PIN_O
);
    import amprc_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // One exact-match helper keeps the write decodes identical, so a new
    // register cannot pick up a partly decoded address by mistake.
    function automatic logic wr_hit(
        input logic       strobe,
        input logic [7:0] addr,
        input logic [7:0] reg_addr
    );
        return strobe && (addr == reg_addr);
    endfunction : wr_hit

    wire wr_coupling = wr_hit(WR_I, ADDR_I, ADDR_INPUT_COUPLING);
    wire wr_sysref   = wr_hit(WR_I, ADDR_I, ADDR_SYSREF_CONTROL);
    wire wr_manual   = wr_hit(WR_I, ADDR_I, ADDR_SYSREF_MANUAL);
    wire wr_pdn      = wr_hit(WR_I, ADDR_I, ADDR_POWERDOWN_CTRL);
    wire wr_perf     = wr_hit(WR_I, ADDR_I, ADDR_PERF_HIGH);
    wire wr_ovr      = wr_hit(WR_I, ADDR_I, ADDR_OVERRANGE_OUT);

    // ------------------------------------------------------------------
    // Control bits
    // ------------------------------------------------------------------
    logic dc_bias_q, sysref_ignore_q, sysref_high_cm_q, sysref_level_q;
    logic sysref_drive_q, pdn_by_reg_q, perf3_q, chb_fast_overrange_flag_q, always_one_q;

    amprc_ctrl_bit u_dc_bias   (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_coupling),
        .wr_bit_i(WDATA_I[BIT_INPUT_DC_BIAS]), .bit_o(dc_bias_q));
    amprc_ctrl_bit u_ignore    (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_sysref),
        .wr_bit_i(WDATA_I[BIT_SYSREF_IGNORE]), .bit_o(sysref_ignore_q));
    amprc_ctrl_bit u_high_cm   (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_sysref),
        .wr_bit_i(WDATA_I[BIT_SYSREF_HIGH_CM]), .bit_o(sysref_high_cm_q));
    amprc_ctrl_bit u_level     (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_sysref),
        .wr_bit_i(WDATA_I[BIT_SYSREF_SOFT_LEVEL]), .bit_o(sysref_level_q));
    amprc_ctrl_bit u_drive     (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_manual),
        .wr_bit_i(WDATA_I[BIT_SYSREF_SOFT_DRIVE]), .bit_o(sysref_drive_q));
    amprc_ctrl_bit u_pdn       (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_pdn),
        .wr_bit_i(WDATA_I[BIT_POWERDOWN_BY_REG]), .bit_o(pdn_by_reg_q));
    amprc_ctrl_bit u_perf3     (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_perf),
        .wr_bit_i(WDATA_I[BIT_PERF_SETTING3]), .bit_o(perf3_q));
    amprc_ctrl_bit u_chb_fast_overrange_flag  (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_ovr),
        .wr_bit_i(WDATA_I[BIT_CHB_FAST_OVERRANGE_FLAG_OUT]), .bit_o(chb_fast_overrange_flag_q));
    amprc_ctrl_bit u_always1   (.clk_i(CLK_I), .resetn_i(RESETN_I), .wr_en_i(wr_ovr),
        .wr_bit_i(WDATA_I[BIT_ALWAYS_ONE]), .bit_o(always_one_q));

    // ------------------------------------------------------------------
    // Behaviour steered by the control bits
    // ------------------------------------------------------------------
    // Manual drive replaces the pin; the ignore bit then forces low so a
    // masked SYSREF can never produce an edge downstream.
    wire       sysref_src = sysref_drive_q ? sysref_level_q : SYSREF_I;
    wire       sysref_d   = sysref_ignore_q ? 1'b0 : sysref_src;
    wire [7:0] mask_sel   = POWERDOWN_TABLE_SELECT_I ? POWERDOWN_MASK2_I : POWERDOWN_MASK1_I;
    wire [7:0] pdn_d      = pdn_by_reg_q ? mask_sel : 8'h00;
    wire       serial_data_out_pin_d    = chb_fast_overrange_flag_q ? FAST_OVERRANGE_FLAG_B_I : SERIAL_DATA_I;
    wire       bias_d     = dc_bias_q ? BIAS_HIGH_5K : BIAS_LOW_600;

    // ------------------------------------------------------------------
    // Read mux: write-only bits and reserved bits read as zero.
    // ------------------------------------------------------------------
    logic [7:0] rdata_d;
    always_comb
    begin
        rdata_d = 8'h00;
        unique case (ADDR_I)
            ADDR_INPUT_COUPLING: rdata_d[BIT_INPUT_DC_BIAS] = dc_bias_q;
            ADDR_SYSREF_CONTROL:
            begin
                rdata_d[BIT_SYSREF_IGNORE]     = sysref_ignore_q;
                rdata_d[BIT_SYSREF_HIGH_CM]    = sysref_high_cm_q;
                rdata_d[BIT_SYSREF_SOFT_LEVEL] = sysref_level_q;
            end
            ADDR_SYSREF_MANUAL:  rdata_d[BIT_SYSREF_SOFT_DRIVE] = sysref_drive_q;
            ADDR_POWERDOWN_CTRL: rdata_d[BIT_POWERDOWN_BY_REG]  = pdn_by_reg_q;
            ADDR_OVERRANGE_OUT:  rdata_d[BIT_ALWAYS_ONE]        = always_one_q;
            default:             rdata_d = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read data is forced to zero outside the answer cycle, so a host that
    // samples a cycle late sees zero instead of a stale byte.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            RDATA_O <= REG_RESET_VALUE;
        end
        else
        begin
            RDATA_O <= RD_I ? rdata_d : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Analog bias and SYSREF outputs
    // ------------------------------------------------------------------
    // Every control output is retimed once, which costs a cycle of latency
    // but keeps the pins free of decode glitches.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            INPUT_DC_BIAS_SELECT_O <= BIAS_LOW_600;
        end
        else
        begin
            INPUT_DC_BIAS_SELECT_O <= bias_d;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            SYSREF_HIGH_CM_ENABLE_O <= 1'b0;
        end
        else
        begin
            SYSREF_HIGH_CM_ENABLE_O <= sysref_high_cm_q;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            SYSREF_O <= 1'b0;
        end
        else
        begin
            SYSREF_O <= sysref_d;
        end
    end

    // ------------------------------------------------------------------
    // Power-down and performance outputs
    // ------------------------------------------------------------------
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            POWERDOWN_BLOCKS_O <= 8'h00;
        end
        else
        begin
            POWERDOWN_BLOCKS_O <= pdn_d;
        end
    end

    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            PERFORMANCE_SETTING3_O <= 1'b0;
        end
        else
        begin
            PERFORMANCE_SETTING3_O <= perf3_q;
        end
    end

    // ------------------------------------------------------------------
    // Serial data output pin
    // ------------------------------------------------------------------
    // The routed overrange flag is a level, so one cycle of delay on the
    // pin does not lose it; a pulse shorter than a clock would be missed.
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            SERIAL_DATA_OUT_PIN_O <= 1'b0;
        end
        else
        begin
            SERIAL_DATA_OUT_PIN_O <= serial_data_out_pin_d;
        end
    end
endmodule : amprc_regs

//--- amprc_regs_props.sv
// Checker for the master page control registers.
// Assumes it is bound to amprc_regs and sees only its ports.
`timescale 1ns/10ps
module amprc_regs_chk (
    input wire logic       CLK_I,
    input wire logic       RESETN_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       SYSREF_I,
    input wire logic       POWERDOWN_TABLE_SELECT_I,
    input wire logic [7:0] POWERDOWN_MASK1_I,
    input wire logic [7:0] POWERDOWN_MASK2_I,
    input wire logic       FAST_OVERRANGE_FLAG_B_I,
    input wire logic       SERIAL_DATA_I,
    input wire logic       INPUT_DC_BIAS_SELECT_O,
    input wire logic       SYSREF_HIGH_CM_ENABLE_O,
    input wire logic       SYSREF_O,
    input wire logic [7:0] POWERDOWN_BLOCKS_O,
    input wire logic       SERIAL_DATA_OUT_PIN_O
);
    // ----------------------------------------------------------------
    // Shadows of the written bytes; up_q skips the edges near reset.
    // ----------------------------------------------------------------
    logic [7:0] s53_q, s54_q, s55_q, s59_q;
    logic [1:0] up_q;
    always_ff @(posedge CLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            {s53_q, s54_q, s55_q, s59_q} <= '0;
            up_q <= 2'h0;
        end
        else
        begin
            up_q <= {up_q[0], 1'b1};
            if (WR_I && ADDR_I == 8'h53) s53_q <= WDATA_I;
            if (WR_I && ADDR_I == 8'h54) s54_q <= WDATA_I;
            if (WR_I && ADDR_I == 8'h55) s55_q <= WDATA_I;
            if (WR_I && ADDR_I == 8'h59) s59_q <= WDATA_I;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    sequence wr_bias; WR_I && ADDR_I == 8'h4F; endsequence
    a_bias_write: assert property (wr_bias |-> ##2 INPUT_DC_BIAS_SELECT_O == $past(WDATA_I[0], 2))
        else $error("bias select missed its write");
    a_sysref_ignore: assert property (up_q[1] && $past(s53_q[6]) |-> !SYSREF_O)
        else $error("ignored sysref reached output");
    a_high_cm: assert property (up_q[1] |-> SYSREF_HIGH_CM_ENABLE_O == $past(s53_q[1]))
        else $error("high common mode enable wrong");
    a_soft_level: assert property (up_q[1] && $past(!s53_q[6] && s54_q[7]) |-> SYSREF_O == $past(s53_q[0]))
        else $error("soft sysref level wrong");
    a_manual_off: assert property (up_q[1] && $past(!s53_q[6] && !s54_q[7]) |-> SYSREF_O == $past(SYSREF_I))
        else $error("sysref input not passed");
    a_pdn_off: assert property (up_q[1] && !$past(s55_q[4]) |-> POWERDOWN_BLOCKS_O == 8'h00)
        else $error("power down without enable");
    a_pdn_table: assert property (up_q[1] && $past(s55_q[4]) |-> POWERDOWN_BLOCKS_O == $past(
        POWERDOWN_TABLE_SELECT_I ? POWERDOWN_MASK2_I : POWERDOWN_MASK1_I))
        else $error("power down mask wrong");
    a_fast_overrange_flag_route: assert property (up_q[1] |-> SERIAL_DATA_OUT_PIN_O == $past(
        s59_q[7] ? FAST_OVERRANGE_FLAG_B_I : SERIAL_DATA_I))
        else $error("serial out source wrong");
endmodule : amprc_regs_chk
bind amprc_regs amprc_regs_chk u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
    .WR_I(WR_I), .SYSREF_I(SYSREF_I), .POWERDOWN_TABLE_SELECT_I(POWERDOWN_TABLE_SELECT_I),
    .POWERDOWN_MASK1_I(POWERDOWN_MASK1_I), .POWERDOWN_MASK2_I(POWERDOWN_MASK2_I),
    .FAST_OVERRANGE_FLAG_B_I(FAST_OVERRANGE_FLAG_B_I), .SERIAL_DATA_I(SERIAL_DATA_I),
    .INPUT_DC_BIAS_SELECT_O(INPUT_DC_BIAS_SELECT_O), .SYSREF_HIGH_CM_ENABLE_O(SYSREF_HIGH_CM_ENABLE_O),
    .SYSREF_O(SYSREF_O), .POWERDOWN_BLOCKS_O(POWERDOWN_BLOCKS_O), .SERIAL_DATA_OUT_PIN_O(SERIAL_DATA_OUT_PIN_O));

//--- amprc_host.sv
// Host model driving the register port one strobe per access.
// Assumes callers hand over whole settings with reserved bits zero.
`timescale 1ns/10ps
module amprc_host (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial {addr_o, wdata_o, wr_o, rd_o} = '0;
    // Released data is inverted so no stale byte looks valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        #1 q = rdata_i;
    endtask : rd
endmodule : amprc_host

//--- adc_master_page_control_regs_tb.sv
// Self-checking bench for the master page control registers.
// Assumes the checker is bound in and the host model drives the port.
`timescale 1ns/10ps
module adc_master_page_control_regs_tb;
    logic clk = 0, rst_n = 0, sysref = 0, tsel = 0, fast_overrange_flag = 0, sdi = 0, wr, rd;
    logic bias, hcm, sref, perf, sdo;
    logic [7:0] addr, wdata, rdata, pdn, m1 = 8'hA5, m2 = 8'h5A;
    int fails = 0, check_count = 0, cycles = 0;
    always #25 clk = ~clk;
    amprc_host u_host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
    amprc_regs u_dut (.CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .SYSREF_I(sysref), .POWERDOWN_TABLE_SELECT_I(tsel), .POWERDOWN_MASK1_I(m1), .POWERDOWN_MASK2_I(m2),
        .FAST_OVERRANGE_FLAG_B_I(fast_overrange_flag), .SERIAL_DATA_I(sdi), .RDATA_O(rdata), .INPUT_DC_BIAS_SELECT_O(bias),
        .SYSREF_HIGH_CM_ENABLE_O(hcm), .SYSREF_O(sref), .POWERDOWN_BLOCKS_O(pdn),
        .PERFORMANCE_SETTING3_O(perf), .SERIAL_DATA_OUT_PIN_O(sdo));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        check_count++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.rd(a, q);
        chk("rdata", e, q);
    endtask : rchk
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask : settle
    task automatic t_reset();
        logic [7:0] a[7] = '{8'h4F, 8'h53, 8'h54, 8'h55, 8'h56, 8'h59, 8'h00};
        foreach (a[i]) rchk(a[i], 8'h00);
        $display("done reset values");
    endtask : t_reset
    task automatic t_sysref();
        u_host.wr(8'h4F, 8'h01);
        u_host.wr(8'h54, 8'h80);
        u_host.wr(8'h53, 8'h03);
        settle();
        chk("bias", 8'h01, 8'(bias));
        chk("sysref", 8'h01, 8'(sref));
        chk("high_cm", 8'h01, 8'(hcm));
        rchk(8'h54, 8'h80);
        @(posedge clk) sysref <= 1'b1;
        u_host.wr(8'h53, 8'h41);
        settle();
        chk("sysref", 8'h00, 8'(sref));
        chk("high_cm", 8'h00, 8'(hcm));
        u_host.wr(8'h53, 8'h00);
        settle();
        chk("sysref", 8'h00, 8'(sref));
        u_host.wr(8'h54, 8'h00);
        u_host.wr(8'h4F, 8'h00);
        settle();
        chk("sysref", 8'h01, 8'(sref));
        chk("bias", 8'h00, 8'(bias));
        $display("done sysref and bias");
    endtask : t_sysref
    task automatic t_pdn_out();
        u_host.wr(8'h55, 8'h10);
        settle();
        chk("pdn", 8'hA5, pdn);
        @(posedge clk) tsel <= 1'b1;
        settle();
        chk("pdn", 8'h5A, pdn);
        @(posedge clk) sdi <= 1'b1;
        u_host.wr(8'h59, 8'hA0);
        u_host.wr(8'h56, 8'h04);
        settle();
        chk("serial_data_out_pin", 8'h00, 8'(sdo));
        chk("perf", 8'h01, 8'(perf));
        rchk(8'h59, 8'h20);
        rchk(8'h56, 8'h00);
        u_host.wr(8'h59, 8'h20);
        u_host.wr(8'h55, 8'h00);
        settle();
        chk("serial_data_out_pin", 8'h01, 8'(sdo));
        chk("pdn", 8'h00, pdn);
        $display("done powerdown and serial out");
    endtask : t_pdn_out
    task automatic print_verdict();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fails++;
            print_verdict();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_sysref();
        t_pdn_out();
        print_verdict();
    end
endmodule : adc_master_page_control_regs_tb
